// File: design/ebpa_pkg.sv
// Package for the external bus pin assignment block: register map,
// control field positions, reset values, machine clock divider, carriers.
// Assumes one 10 MHz clock and the plain register port of the block.
`default_nettype none

package ebpa_pkg;

	// ----------------------------------------------------------------
	// Sizes
	// ----------------------------------------------------------------
	localparam int unsigned NPORT = 5;
	localparam int unsigned RADDR_W = 5;
	localparam int unsigned RDATA_W = 8;

	// Port slots in the pin arrays
	localparam int unsigned SLOT_P0 = 0;
	localparam int unsigned SLOT_P1 = 1;
	localparam int unsigned SLOT_P3 = 2;
	localparam int unsigned SLOT_P4 = 3;
	localparam int unsigned SLOT_P5 = 4;

	// ----------------------------------------------------------------
	// Register offsets (word index = byte offset on this port)
	// ----------------------------------------------------------------
	localparam logic [4:0] OFS_BUS_PIN_CONTROL_REG = 5'h00;
	localparam logic [4:0] OFS_STATUS = 5'h01;
	localparam logic [4:0] OFS_DATA_BASE = 5'h02;
	localparam logic [4:0] OFS_DIR_BASE = 5'h07;
	localparam logic [4:0] OFS_PIN_BASE = 5'h0C;

	// ----------------------------------------------------------------
	// Control register fields
	// ----------------------------------------------------------------
	localparam int unsigned EXT_BUS_MODE = 0;
	localparam int unsigned MUX_MODE = 1;
	localparam int unsigned BUS_16BIT = 2;
	localparam int unsigned WRITE_STROBE_ENABLE = 3;
	localparam int unsigned HOLD_PINS_ENABLE = 4;
	localparam int unsigned READY_PIN_ENABLE = 5;
	localparam int unsigned CLOCK_OUT_ENABLE = 6;

	// Status register fields
	localparam int unsigned STAT_HOLD_REQ = 0;
	localparam int unsigned STAT_READY = 1;
	localparam int unsigned STAT_HOLD_ACK = 2;

	// Port 5 line positions
	localparam int unsigned PORT5_LINE0 = 0;
	localparam int unsigned PORT5_RD_LINE = 1;
	localparam int unsigned PORT5_WR_LOW_LINE = 2;
	localparam int unsigned PORT5_WR_HIGH_LINE = 3;
	localparam int unsigned PORT5_HOLD_REQ_LINE = 4;
	localparam int unsigned PORT5_HOLD_ACK_LINE = 5;
	localparam int unsigned PORT5_RDY_LINE = 6;
	localparam int unsigned PORT5_CLK_LINE = 7;

	// ----------------------------------------------------------------
	// Reset values and timing
	// ----------------------------------------------------------------
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [7:0] PORT_DATA_RESET = 8'h00;
	localparam logic [7:0] PORT_DIR_RESET = 8'h00;
	localparam logic [1:0] MCLK_HALF_CYCLES = 2'h2;

	// ----------------------------------------------------------------
	// Carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [7:0] dout;
		logic [7:0] oe_n;
	} ebpa_pin_drv_type;

	typedef struct packed {
		logic [15:0] addr;
		logic [15:0] wdata;
		logic data_oe;
		logic ale;
		logic rd_n;
		logic low_byte_write_strobe_n;
		logic high_byte_write_strobe_n;
		logic hold_ack;
	} ebpa_bus_req_type;

	typedef struct packed {
		logic [15:0] rdata;
		logic hold_request_in;
		logic ready;
	} ebpa_bus_rsp_type;

endpackage

`default_nettype wire

// File: design/ebpa_pin_mux.sv
// Pin multiplexer for the shared port pins of the external parallel bus.
// Assumes an internal bus controller on the same clock drives bus_req and
// reads bus_rsp; pin inputs arrive asynchronously from the board.
// Function
// [RULE_01] In non-multiplex bus mode ports 3 and 4 drive address lines 0 to 15.
// [RULE_02] In external bus mode port 5 line 0 carries the address latch enable.
// [RULE_03] In external bus mode port 5 line 1 carries the active-low read strobe.
// [RULE_04] Port 5 line 2 carries the low-byte write strobe when strobes are enabled.
// [RULE_05] Port 5 line 3 carries the high-byte write strobe only on a 16-bit bus.
// [RULE_06] With hold pins enabled port 5 line 4 takes the hold request from outside.
// [RULE_07] With hold pins enabled port 5 line 5 drives the hold acknowledge.
// [RULE_08] With ready enabled port 5 line 6 samples the external ready input.
// [RULE_09] With clock output enabled port 5 line 7 drives the machine-cycle clock.
// [RULE_10] Multiplex mode puts address and data on ports 0 and 1, else data only.
// [RULE_11] A pin given to a bus function ignores its port data and direction.
//
// The register offsets and the address-and-strobe port are this design's own decisions.
`default_nettype none

module ebpa_pin_mux
	import ebpa_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Register port
	input wire logic [RADDR_W-1:0] reg_addr,
	input wire logic [RDATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [RDATA_W-1:0] reg_rdata,
	// Internal bus controller
	input var ebpa_bus_req_type bus_req,
	output var ebpa_bus_rsp_type bus_rsp,
	// Shared pins
	input wire logic [NPORT-1:0][7:0] pin_in,
	output var ebpa_pin_drv_type [NPORT-1:0] pin_drv
);

	// ----------------------------------------------------------------
	// Decode
	// ----------------------------------------------------------------
	function automatic logic slot_hit(logic [4:0] addr, logic [4:0] base, int unsigned k);
		return addr == 5'(base + 5'(k));
	endfunction

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	logic [7:0] ctrl_q, ctrl_d;
	logic [NPORT-1:0][7:0] data_q, data_d;
	logic [NPORT-1:0][7:0] dir_q, dir_d;
	logic [7:0] rdata_q, rdata_d;
	logic [NPORT-1:0][7:0] sync1_q, sync2_q;
	ebpa_pin_drv_type [NPORT-1:0] drv_q, drv_d;
	ebpa_bus_rsp_type rsp_q, rsp_d;
	logic [1:0] div_q, div_d;
	logic mclk_q, mclk_d;

	logic ext, mux, wide;
	assign ext = ctrl_q[EXT_BUS_MODE];
	assign mux = ctrl_q[MUX_MODE];
	assign wide = ctrl_q[BUS_16BIT];

	always_comb begin
		ctrl_d = ctrl_q;
		data_d = data_q;
		dir_d = dir_q;
		rdata_d = rdata_q;
		if (reg_wr) begin
			if (reg_addr == OFS_BUS_PIN_CONTROL_REG) begin
				ctrl_d = {1'b0, reg_wdata[6:0]};
			end
			for (int k = 0; k < NPORT; k++) begin
				if (slot_hit(reg_addr, OFS_DATA_BASE, k)) begin
					data_d[k] = reg_wdata;
				end
				if (slot_hit(reg_addr, OFS_DIR_BASE, k)) begin
					dir_d[k] = reg_wdata;
				end
			end
		end
		if (reg_rd) begin
			rdata_d = 8'h00;
			if (reg_addr == OFS_BUS_PIN_CONTROL_REG) begin
				rdata_d = ctrl_q;
			end
			if (reg_addr == OFS_STATUS) begin
				rdata_d[STAT_HOLD_REQ] = rsp_q.hold_request_in;
				rdata_d[STAT_READY] = rsp_q.ready;
				rdata_d[STAT_HOLD_ACK] = bus_req.hold_ack;
			end
			for (int k = 0; k < NPORT; k++) begin
				if (slot_hit(reg_addr, OFS_DATA_BASE, k)) begin
					rdata_d = data_q[k];
				end
				if (slot_hit(reg_addr, OFS_DIR_BASE, k)) begin
					rdata_d = dir_q[k];
				end
				if (slot_hit(reg_addr, OFS_PIN_BASE, k)) begin
					rdata_d = sync2_q[k];
				end
			end
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			ctrl_q <= CTRL_RESET;
			data_q <= {NPORT{PORT_DATA_RESET}};
			dir_q <= {NPORT{PORT_DIR_RESET}};
			rdata_q <= 8'h00;
		end else begin
			ctrl_q <= ctrl_d;
			data_q <= data_d;
			dir_q <= dir_d;
			rdata_q <= rdata_d;
		end
	end

	// Read data stand only in the cycle after the strobe
	logic rd_seen_q;
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rd_seen_q <= 1'b0;
		end else begin
			rd_seen_q <= reg_rd;
		end
	end
	assign reg_rdata = rd_seen_q ? rdata_q : 8'h00;

	// ----------------------------------------------------------------
	// Pin input synchronisers
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			sync1_q <= '0;
			sync2_q <= '0;
		end else begin
			sync1_q <= pin_in;
			sync2_q <= sync1_q;
		end
	end

	// ----------------------------------------------------------------
	// Machine-cycle clock divider
	// ----------------------------------------------------------------
	always_comb begin
		div_d = div_q + 2'h1;
		mclk_d = mclk_q;
		if (div_q == MCLK_HALF_CYCLES - 2'h1) begin
			div_d = 2'h0;
			mclk_d = ~mclk_q;
		end
	end

	// ----------------------------------------------------------------
	// Pin function selection
	// ----------------------------------------------------------------
	always_comb begin
		// Plain port behaviour unless a bus function claims the pin
		for (int k = 0; k < NPORT; k++) begin
			drv_d[k].dout = data_q[k];
			drv_d[k].oe_n = ~dir_q[k];
		end
		rsp_d.rdata = {sync2_q[SLOT_P1], sync2_q[SLOT_P0]};
		rsp_d.hold_request_in = 1'b0;
		rsp_d.ready = 1'b1;
		if (ext) begin
			// Address phase on ale in multiplex mode, data otherwise
			if (mux && bus_req.ale) begin
				drv_d[SLOT_P0].dout = bus_req.addr[7:0]; // [RULE_10] [RULE_11]
				drv_d[SLOT_P0].oe_n = 8'h00;
			end else begin
				drv_d[SLOT_P0].dout = bus_req.wdata[7:0]; // [RULE_10] [RULE_11]
				drv_d[SLOT_P0].oe_n = bus_req.data_oe ? 8'h00 : 8'hFF;
			end
			// An 8-bit non-multiplexed bus leaves the high data byte to the port
			if (mux || wide) begin
				if (mux && bus_req.ale) begin
					drv_d[SLOT_P1].dout = bus_req.addr[15:8]; // [RULE_10] [RULE_11]
					drv_d[SLOT_P1].oe_n = 8'h00;
				end else begin
					drv_d[SLOT_P1].dout = bus_req.wdata[15:8]; // [RULE_10] [RULE_11]
					drv_d[SLOT_P1].oe_n = bus_req.data_oe ? 8'h00 : 8'hFF;
				end
			end
			if (!mux) begin
				drv_d[SLOT_P3].dout = bus_req.addr[7:0]; // [RULE_01] [RULE_11]
				drv_d[SLOT_P3].oe_n = 8'h00;
				drv_d[SLOT_P4].dout = bus_req.addr[15:8]; // [RULE_01] [RULE_11]
				drv_d[SLOT_P4].oe_n = 8'h00;
			end
			drv_d[SLOT_P5].dout[PORT5_LINE0] = bus_req.ale; // [RULE_02] [RULE_11]
			drv_d[SLOT_P5].oe_n[PORT5_LINE0] = 1'b0;
			drv_d[SLOT_P5].dout[PORT5_RD_LINE] = bus_req.rd_n; // [RULE_03] [RULE_11]
			drv_d[SLOT_P5].oe_n[PORT5_RD_LINE] = 1'b0;
			if (ctrl_q[WRITE_STROBE_ENABLE]) begin
				drv_d[SLOT_P5].dout[PORT5_WR_LOW_LINE] = bus_req.low_byte_write_strobe_n; // [RULE_04]
				drv_d[SLOT_P5].oe_n[PORT5_WR_LOW_LINE] = 1'b0;
				if (wide) begin
					drv_d[SLOT_P5].dout[PORT5_WR_HIGH_LINE] = bus_req.high_byte_write_strobe_n; // [RULE_05]
					drv_d[SLOT_P5].oe_n[PORT5_WR_HIGH_LINE] = 1'b0;
				end
			end
			if (ctrl_q[HOLD_PINS_ENABLE]) begin
				drv_d[SLOT_P5].oe_n[PORT5_HOLD_REQ_LINE] = 1'b1; // [RULE_06] [RULE_11]
				rsp_d.hold_request_in = sync2_q[SLOT_P5][PORT5_HOLD_REQ_LINE]; // [RULE_06]
				drv_d[SLOT_P5].dout[PORT5_HOLD_ACK_LINE] = ~bus_req.hold_ack; // [RULE_07]
				drv_d[SLOT_P5].oe_n[PORT5_HOLD_ACK_LINE] = 1'b0;
			end
			if (ctrl_q[READY_PIN_ENABLE]) begin
				drv_d[SLOT_P5].oe_n[PORT5_RDY_LINE] = 1'b1; // [RULE_08] [RULE_11]
				rsp_d.ready = sync2_q[SLOT_P5][PORT5_RDY_LINE]; // [RULE_08]
			end
			if (ctrl_q[CLOCK_OUT_ENABLE]) begin
				drv_d[SLOT_P5].dout[PORT5_CLK_LINE] = mclk_q; // [RULE_09]
				drv_d[SLOT_P5].oe_n[PORT5_CLK_LINE] = 1'b0;
			end
		end
	end

	// Registered pins cost one cycle of latency but give glitch-free strobes
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			drv_q <= {NPORT{16'h00FF}};
			rsp_q <= {16'h0000, 1'b0, 1'b1};
			div_q <= 2'h0;
			mclk_q <= 1'b0;
		end else begin
			drv_q <= drv_d;
			rsp_q <= rsp_d;
			div_q <= div_d;
			mclk_q <= mclk_d;
		end
	end

	assign pin_drv = drv_q;
	assign bus_rsp = rsp_q;

endmodule

`default_nettype wire

// File: tb/ebpa_pin_mux_sva.sv
// Checker on the ports of the pin multiplexer.
// Assumes one clock and the control register at its own offset.
`default_nettype none
module ebpa_pin_mux_sva
	import ebpa_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Register port
	input wire logic [RADDR_W-1:0] reg_addr,
	input wire logic [RDATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [RDATA_W-1:0] reg_rdata,
	// Bus and pins
	input var ebpa_bus_req_type bus_req,
	input var ebpa_bus_rsp_type bus_rsp,
	input wire logic [NPORT-1:0][7:0] pin_in,
	input var ebpa_pin_drv_type [NPORT-1:0] pin_drv
);
	// ----
	// Control shadow
	// ----
	logic [6:0] c_q, c_d;
	logic nm, wl, wh, ho, ry, ck, ma;
	logic [7:0] o5, d5;
	always_comb begin
		c_d = c_q;
		if (reg_wr && reg_addr == OFS_BUS_PIN_CONTROL_REG)
			c_d = reg_wdata[6:0];
	end
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			c_q <= '0;
		else
			c_q <= c_d;
	end
	assign nm = c_q[0] & ~c_q[1];
	assign wl = c_q[0] & c_q[3];
	assign wh = wl & c_q[2];
	assign ho = c_q[0] & c_q[4];
	assign ry = c_q[0] & c_q[5];
	assign ck = c_q[0] & c_q[6];
	assign ma = c_q[0] & c_q[1] & bus_req.ale;
	assign o5 = pin_drv[SLOT_P5].oe_n;
	assign d5 = pin_drv[SLOT_P5].dout;
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	// Inputs pass a two-flop sync, so hold the mode long enough
	sequence s_hold_on; ho [*4]; endsequence
	sequence s_rdy_on; ry [*4]; endsequence
	a_addr_out: assert property (
		$past(nm) |-> {pin_drv[SLOT_P4].oe_n, pin_drv[SLOT_P3].oe_n} == 16'h0000
		&& {pin_drv[SLOT_P4].dout, pin_drv[SLOT_P3].dout} == $past(bus_req.addr))
		else $error("address lines wrong");
	a_ale_rd: assert property (
		$past(c_q[0]) |-> o5[1:0] == 2'h0 && d5[0] == $past(bus_req.ale)
		&& d5[1] == $past(bus_req.rd_n)) else $error("ale or read strobe wrong");
	a_low_write: assert property (
		$past(wl) |-> !o5[2] && d5[2] == $past(bus_req.low_byte_write_strobe_n))
		else $error("low write strobe wrong");
	a_high_write: assert property (
		$past(wh) |-> !o5[3] && d5[3] == $past(bus_req.high_byte_write_strobe_n))
		else $error("high write strobe wrong");
	a_hold_ack: assert property (
		$past(ho) |-> o5[5:4] == 2'h1 && d5[5] == !$past(bus_req.hold_ack))
		else $error("hold pins wrong");
	a_hold_req: assert property (
		s_hold_on |-> bus_rsp.hold_request_in == $past(pin_in[SLOT_P5][4], 3))
		else $error("hold request not passed");
	a_ready_in: assert property (
		s_rdy_on |-> o5[6] && bus_rsp.ready == $past(pin_in[SLOT_P5][6], 3))
		else $error("ready not passed");
	a_ready_off: assert property (
		!ry [*4] |-> bus_rsp.ready) else $error("ready low while unused");
	a_clock_out: assert property (
		ck [*4] |-> !o5[7] && d5[7] != $past(d5[7], 2))
		else $error("machine clock wrong");
	a_mux_addr: assert property (
		$past(ma) |-> {pin_drv[SLOT_P1].oe_n, pin_drv[SLOT_P0].oe_n} == 16'h0000
		&& {pin_drv[SLOT_P1].dout, pin_drv[SLOT_P0].dout} == $past(bus_req.addr))
		else $error("multiplexed address wrong");
	// Sync flops clear in reset, so wait three clean edges
	a_data_in: assert property (
		$past(rstn, 3) |-> bus_rsp.rdata[15:8] == $past(pin_in[SLOT_P1], 3)
		&& bus_rsp.rdata[7:0] == $past(pin_in[SLOT_P0], 3))
		else $error("data pins not passed");
endmodule
bind ebpa_pin_mux ebpa_pin_mux_sva u_sva (.clk(clk), .rstn(rstn), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.bus_req(bus_req), .bus_rsp(bus_rsp), .pin_in(pin_in), .pin_drv(pin_drv));
`default_nettype wire

// File: tb/ebpa_ext_mem.sv
// Far side of the shared pins: memory or a peripheral on the bus.
// Assumes the bench sets request, ready and read data levels.
`default_nettype none
module ebpa_ext_mem
	import ebpa_pkg::*;
(
	// Levels from the bench
	input wire logic clk,
	input wire logic hreq,
	input wire logic rdy,
	input wire logic [15:0] rd_word,
	// Pins
	input var ebpa_pin_drv_type [NPORT-1:0] pin_drv,
	output logic [NPORT-1:0][7:0] pin_in
);
	logic [7:0] junk_q = 8'hA5;
	logic [NPORT-1:0][7:0] ext;
	// Released lines wander, so a stale level never passes
	always @(posedge clk) junk_q <= ~junk_q;
	always_comb begin
		for (int s = 0; s < NPORT; s++)
			ext[s] = junk_q;
		if (!pin_drv[SLOT_P5].dout[1] && !pin_drv[SLOT_P5].oe_n[1]) begin
			ext[SLOT_P0] = rd_word[7:0];
			ext[SLOT_P1] = rd_word[15:8];
		end
		ext[SLOT_P5][4] = hreq;
		ext[SLOT_P5][6] = rdy;
		for (int s = 0; s < NPORT; s++)
			pin_in[s] = (pin_drv[s].dout & ~pin_drv[s].oe_n) | (ext[s] & pin_drv[s].oe_n);
	end
endmodule
`default_nettype wire

// File: tb/tb_ebpa_pin_mux.sv
// Bench: random modes and bus levels, checked through register reads.
// Assumes the checker binds itself and the far-side model resolves pins.
`default_nettype none
module tb_ebpa_pin_mux
	import ebpa_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 0, rstn = 0, reg_wr = 0, reg_rd = 0, hreq = 0, rdy = 1, rd_q = 0;
	logic [4:0] reg_addr = '0;
	logic [7:0] reg_wdata = '0, reg_rdata, c;
	ebpa_bus_req_type bus_req = '0;
	ebpa_bus_rsp_type bus_rsp;
	logic [15:0] rd_word = '0, v, e;
	logic [NPORT-1:0][7:0] pin_in, pd;
	ebpa_pin_drv_type [NPORT-1:0] pin_drv;
	logic [31:0] rs = 32'h02F6, r0;
	logic [15:0] q[$];
	int err_total = 0, samples_checked = 0, cyc = 0;
	ebpa_pin_mux dut (.clk(clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .bus_req(bus_req),
		.bus_rsp(bus_rsp), .pin_in(pin_in), .pin_drv(pin_drv));
	ebpa_ext_mem far (.clk(clk), .hreq(hreq), .rdy(rdy), .rd_word(rd_word),
		.pin_drv(pin_drv), .pin_in(pin_in));
	initial begin
		forever #50 clk = ~clk;
	end
	function automatic logic [31:0] xs(input logic [31:0] x);
		x ^= x << 13;
		x ^= x >> 17;
		x ^= x << 5;
		return x;
	endfunction
	// Expected pin level and mask per slot; undriven bus lines are masked
	function automatic logic [15:0] ev(input int s);
		logic [7:0] a, w, o;
		a = bus_req.addr[8*(s%2) +: 8];
		w = bus_req.wdata[8*(s%2) +: 8];
		o = {c[6], c[5], c[4], c[4], c[3] & c[2], c[3], 2'h3} & {8{c[0]}};
		if (s == 4)
			return {~(o & 8'h80), ({1'h0, rdy, !bus_req.hold_ack, hreq,
				bus_req.high_byte_write_strobe_n, bus_req.low_byte_write_strobe_n,
				bus_req.rd_n, bus_req.ale} & o) | (pd[4] & ~o)};
		if (s > 1)
			return {8'hFF, c[0] && !c[1] ? a : pd[s]};
		if (!c[0] || (s == 1 && !c[1] && !c[2]))
			return {8'hFF, pd[s]};
		if (c[1] && bus_req.ale)
			return {8'hFF, a};
		return bus_req.data_oe ? {8'hFF, w} : 16'h0000;
	endfunction
	task wr(input logic [4:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_wr <= 1'h1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'h0;
	endtask
	task rd(input logic [4:0] a, input logic [7:0] x, input logic [7:0] m);
		@(posedge clk);
		reg_rd <= 1'h1;
		reg_addr <= a;
		q.push_back({m, x & m});
		@(posedge clk);
		reg_rd <= 1'h0;
	endtask
	task chk(input logic [7:0] g, input logic [7:0] x);
		samples_checked++;
		if (g !== x) begin
			err_total++;
			$display("CHECK FAILED %0t read %h want %h", $time, g, x);
		end
	endtask
	task end_sim;
		if (err_total == 0 && samples_checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// Read data stand only in the cycle after the strobe
	always @(posedge clk) begin
		if (rd_q) begin
			e = q.pop_front();
			chk(reg_rdata & e[15:8], e[7:0]);
		end
		rd_q <= reg_rd;
	end
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			err_total++;
			end_sim;
		end
	end
	initial begin
		repeat (12) @(posedge clk);
		rstn <= 1'h1;
		for (int a = 0; a < 32; a++)
			if (a < 12 || a > 16)
				rd(5'(a), {6'h00, a == 1, 1'h0}, a == 1 ? 8'h03 : 8'hFF);
		wr(5'h1F, 8'hFF);
		rd(5'h1F, 8'h00, 8'hFF);
		// All ports outputs, so bus ownership must override them
		for (int s = 0; s < NPORT; s++) begin
			rs = xs(rs);
			pd[s] = rs[7:0];
			wr(OFS_DATA_BASE + 5'(s), pd[s]);
			wr(OFS_DIR_BASE + 5'(s), 8'hFF);
		end
		repeat (40) begin
			r0 = xs(rs);
			rs = xs(r0);
			c = r0[7:0];
			hreq <= r0[8];
			rdy <= r0[9];
			rd_word <= r0[31:16];
			bus_req <= {rs, r0[15:10]};
			wr(OFS_BUS_PIN_CONTROL_REG, c);
			repeat (8) @(posedge clk);
			rd(OFS_BUS_PIN_CONTROL_REG, c & 8'h7F, 8'hFF);
			rd(OFS_STATUS,
				{5'h00, bus_req.hold_ack, !(c[0] && c[5]) || rdy, c[0] && c[4] && hreq}, 8'h07);
			for (int s = 0; s < NPORT; s++) begin
				v = ev(s);
				rd(OFS_PIN_BASE + 5'(s), v[7:0], v[15:8]);
			end
		end
		// Last read is compared two edges after its strobe
		repeat (2) @(posedge clk);
		end_sim;
	end
endmodule
`default_nettype wire
